// ### src/svc_pkg.sv
package svc_pkg;
  localparam int unsigned AW          = 6;
  localparam int unsigned DEPTH       = 64;
  localparam logic [7:0]  TRS_FIRST   = 8'hFF;
  localparam logic [7:0]  TRS_ZERO    = 8'h00;
  localparam int unsigned TRS_H_BIT   = 4;
  localparam logic [5:0]  CNT_MASK    = 6'h3F;
  localparam logic [5:0]  NOMINAL_CNT = 6'h25;
  localparam logic [5:0]  PAYLOAD_LEN = 6'h23;
  localparam logic [5:0]  INTERNAL_ID_SECOND_IDX    = 6'h03;
  localparam logic [5:0]  BC_BACK     = 6'h04;
  localparam logic [5:0]  MIN_CAPTURE = 6'h30;
  localparam logic [7:0]  BC_RESET    = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CAPT = 2'b01,
    ST_SCAN = 2'b10,
    ST_EMIT = 2'b11
  } svc_state_t;
endpackage : svc_pkg

// ### src/svc_trs_detect.sv
`timescale 1ns/10ps
`default_nettype none
// spots ff 00 00 xy; the xy byte marks start or end of active video
module svc_trs_detect (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [7:0] byte_in,
  input  wire logic       byte_vld,
  output logic            sav_pulse,
  output logic            eav_pulse
);
  import svc_pkg::*;

  logic [7:0] h0_ff;
  logic [7:0] h1_ff;
  logic [7:0] h2_ff;
  wire        preamble = (h2_ff == TRS_FIRST) && (h1_ff == TRS_ZERO) && (h0_ff == TRS_ZERO);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      h0_ff <= 8'h00;
      h1_ff <= 8'h00;
      h2_ff <= 8'h00;
    end else if (byte_vld) begin
      h0_ff <= byte_in;
      h1_ff <= h0_ff;
      h2_ff <= h1_ff;
    end
  end

  assign sav_pulse = byte_vld && preamble && !byte_in[TRS_H_BIT];
  assign eav_pulse = byte_vld && preamble && byte_in[TRS_H_BIT];
endmodule : svc_trs_detect
`default_nettype wire

// ### src/svc_corrector.sv
`timescale 1ns/10ps
`default_nettype none
module svc_corrector (
  input  wire logic       CLK,
  input  wire logic       RESETN,
  input  wire logic [7:0] VID_BYTE,
  input  wire logic       VID_VALID,
  input  wire logic       ZERO_SKIP_MODE,
  output logic [7:0]      TEXT_DATA,
  output logic            TEXT_VALID,
  output logic            TEXT_FIRST,
  output logic            TEXT_LAST,
  output logic [7:0]      PAYLOAD_BYTE_COUNT,
  output logic            CORRECTED,
  output logic            BUSY
);
  import svc_pkg::*;

  function automatic logic [5:0] strip_count(input logic [7:0] bc);
    strip_count = bc[5:0] & CNT_MASK;
  endfunction : strip_count

  logic [7:0]  mem [DEPTH];
  svc_state_t  state_ff;
  svc_state_t  nxt_state;
  logic [AW:0] wr_ff;
  logic [5:0]  rd_ff;
  logic [5:0]  cnt_ff;
  logic [7:0]  bc_ff;
  logic        flag_ff;
  logic        mode_meta_ff;
  logic        mode_ff;
  logic        pkt_mode_ff;
  logic [7:0]  data_ff;
  logic        valid_ff;
  logic        first_ff;
  logic        last_ff;
  logic        sav_pulse;
  logic        eav_pulse;

  svc_trs_detect u_trs (
    .clk       (CLK),
    .resetn    (RESETN),
    .byte_in   (VID_BYTE),
    .byte_vld  (VID_VALID),
    .sav_pulse (sav_pulse),
    .eav_pulse (eav_pulse)
  );

  // writes stop at DEPTH so an over-long line cannot wrap over the header
  wire        store     = (state_ff == ST_CAPT) && VID_VALID && !eav_pulse && !wr_ff[AW];
  wire [5:0]  wr_addr   = wr_ff[AW-1:0];
  wire [AW:0] bc_idx_w  = wr_ff - {1'b0, BC_BACK};
  wire [5:0]  bc_idx    = bc_idx_w[AW-1:0];
  wire [7:0]  bc_byte   = mem[bc_idx];
  wire [5:0]  new_cnt   = strip_count(bc_byte);
  wire [5:0]  cur_cnt   = strip_count(bc_ff);
  // spurious bytes only ever add to the count, so a low count drops nothing
  wire [5:0]  excess    = (cur_cnt > NOMINAL_CNT) ? cur_cnt - NOMINAL_CNT : 6'h00;
  wire [5:0]  cnt_start = INTERNAL_ID_SECOND_IDX + 6'h01 + excess;
  wire [5:0]  hdr_next  = INTERNAL_ID_SECOND_IDX + 6'h01;
  wire [7:0]  rd_byte   = mem[rd_ff];
  wire        scan_stop = (rd_byte != 8'h00) || (rd_ff == (MIN_CAPTURE - PAYLOAD_LEN));
  wire        end_ok    = eav_pulse && (wr_ff >= {1'b0, MIN_CAPTURE});
  wire        emit_end  = (state_ff == ST_EMIT) && (cnt_ff == PAYLOAD_LEN - 6'h01);
  // count method jumps straight past the spurious bytes on the first beat
  wire [5:0] emit_addr = (state_ff == ST_EMIT && cnt_ff == 6'h00 && !pkt_mode_ff) ?
                         cnt_start : rd_ff;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (sav_pulse) begin
          nxt_state = ST_CAPT;
        end
      end
      ST_CAPT: begin
        if (sav_pulse) begin
          nxt_state = ST_CAPT;
        end else if (end_ok) begin
          nxt_state = pkt_mode_ff ? ST_SCAN : ST_EMIT;
        end else if (eav_pulse) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_SCAN: begin
        if (scan_stop) begin
          nxt_state = ST_EMIT;
        end
      end
      ST_EMIT: begin
        if (emit_end) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // mode pin is asynchronous to CLK, two flops before use
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      mode_meta_ff <= 1'b0;
      mode_ff      <= 1'b0;
    end else begin
      mode_meta_ff <= ZERO_SKIP_MODE;
      mode_ff      <= mode_meta_ff;
    end
  end

  always_ff @(posedge CLK) begin
    if (store) begin
      mem[wr_addr] <= VID_BYTE;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      state_ff    <= ST_IDLE;
      wr_ff       <= '0;
      pkt_mode_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (sav_pulse && (state_ff == ST_IDLE || state_ff == ST_CAPT)) begin
        wr_ff       <= '0;
        pkt_mode_ff <= mode_ff;
      end else if (store) begin
        wr_ff <= wr_ff + {{AW{1'b0}}, 1'b1};
      end
    end
  end

  // count byte and flag are latched once per packet at the end code
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      bc_ff   <= BC_RESET;
      flag_ff <= 1'b0;
    end else if (state_ff == ST_CAPT && end_ok) begin
      bc_ff   <= bc_byte;
      flag_ff <= (new_cnt != NOMINAL_CNT);
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      rd_ff <= '0;
    end else if (state_ff == ST_CAPT) begin
      rd_ff <= hdr_next;
    end else if (state_ff == ST_SCAN && !scan_stop) begin
      rd_ff <= rd_ff + 6'h01;
    end else if (state_ff == ST_EMIT) begin
      // follow the jump so later beats continue past the dropped bytes
      rd_ff <= emit_addr + 6'h01;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      cnt_ff <= '0;
    end else if (state_ff == ST_EMIT) begin
      cnt_ff <= cnt_ff + 6'h01;
    end else begin
      cnt_ff <= '0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      data_ff  <= 8'h00;
      valid_ff <= 1'b0;
      first_ff <= 1'b0;
      last_ff  <= 1'b0;
    end else begin
      data_ff  <= (state_ff == ST_EMIT) ? mem[emit_addr] : 8'h00;
      valid_ff <= (state_ff == ST_EMIT);
      first_ff <= (state_ff == ST_EMIT) && (cnt_ff == 6'h00);
      last_ff  <= emit_end;
    end
  end

  // beat index of the running burst, only for the length check below
  logic [5:0] beat_ff;
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      beat_ff <= '0;
    end else if (TEXT_VALID && !TEXT_LAST) begin
      beat_ff <= beat_ff + 6'h01;
    end else begin
      beat_ff <= '0;
    end
  end

  assign TEXT_DATA          = data_ff;
  assign TEXT_VALID         = valid_ff;
  assign TEXT_FIRST         = first_ff;
  assign TEXT_LAST          = last_ff;
  assign PAYLOAD_BYTE_COUNT = {2'b00, cur_cnt};
  assign CORRECTED          = flag_ff;
  // new packets are not captured while one is being emitted
  assign BUSY               = (state_ff == ST_SCAN) || (state_ff == ST_EMIT);

  a_emit_length: assert property (@(posedge CLK) disable iff (!RESETN)
    (TEXT_VALID || beat_ff != 6'h00) |-> TEXT_VALID && (TEXT_FIRST == (beat_ff == 6'h00)) &&
      (TEXT_LAST == (beat_ff == PAYLOAD_LEN - 6'h01)))
    else $error("payload burst is not 35 bytes");
  a_flag_match: assert property (@(posedge CLK) disable iff (!RESETN)
    TEXT_FIRST |-> (CORRECTED == (PAYLOAD_BYTE_COUNT != 8'h25)))
    else $error("correction flag disagrees with count");
  a_parity_strip: assert property (@(posedge CLK) disable iff (!RESETN)
    (state_ff == ST_CAPT && end_ok) |=> PAYLOAD_BYTE_COUNT == {2'b00, bc_ff[5:0]})
    else $error("parity bit leaked into count");
  a_skip_start: assert property (@(posedge CLK) disable iff (!RESETN)
    (state_ff == ST_EMIT && cnt_ff == 6'h00 && !pkt_mode_ff)
      |-> emit_addr == 6'h04 + excess)
    else $error("wrong number of bytes dropped");
  a_count_pos: assert property (@(posedge CLK) disable iff (!RESETN)
    (state_ff == ST_CAPT && end_ok) |=> bc_ff == $past(bc_byte))
    else $error("count byte not taken before end code");
  a_sav_clear: assert property (@(posedge CLK) disable iff (!RESETN)
    (sav_pulse && state_ff == ST_IDLE) |=> (wr_ff == '0) && (state_ff == ST_CAPT))
    else $error("start code was stored");
  a_first_nonzero: assert property (@(posedge CLK) disable iff (!RESETN)
    (state_ff == ST_SCAN && rd_byte != 8'h00) |=> ##1 (TEXT_FIRST && TEXT_DATA != 8'h00))
    else $error("zero-skip emitted a zero first byte");
  a_mode_reset: assert property (@(posedge CLK)
    !RESETN |=> !mode_ff && !pkt_mode_ff)
    else $error("method not count-based after reset");
  a_store_bound: assert property (@(posedge CLK) disable iff (!RESETN)
    wr_ff <= 7'(DEPTH))
    else $error("capture pointer overran store");

  c_nominal:   cover property (@(posedge CLK) disable iff (!RESETN)
    TEXT_FIRST && !CORRECTED);
  c_corrected: cover property (@(posedge CLK) disable iff (!RESETN)
    TEXT_FIRST && CORRECTED && !pkt_mode_ff);
  c_zero_skip: cover property (@(posedge CLK) disable iff (!RESETN)
    state_ff == ST_SCAN ##1 state_ff == ST_SCAN);
endmodule : svc_corrector
`default_nettype wire

// ### verification/svc_decoder_model.sv
`timescale 1ns/10ps
`default_nettype none
// image port of the decoder: one sliced packet per go pulse
module svc_decoder_model (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [3:0] excess,
  input  wire logic [7:0] spur_val,
  output logic [7:0]      vid_byte,
  output logic            vid_valid
);
  int i;

  function automatic logic [7:0] pkt_byte(input int n);
    logic [5:0] bc;
    int         j;
    bc = 6'h25 + 6'(excess);
    j  = n - 4;
    if (n < 4) return (n == 0) ? 8'hFF : (n == 3) ? 8'h80 : 8'h00;
    if (n > 51) return (n == 52) ? 8'hFF : (n == 55) ? 8'h9D : 8'h00;
    if (j == 0) return 8'h55;
    if (j == 1) return 8'h0B;
    if (j == 2) return 8'h11;
    if (j == 3) return 8'h22;
    // inserted bytes land right behind the second internal id
    if (j < 4 + excess) return spur_val;
    if (j < 39 + excess) return 8'h40 + 8'(j - 4 - excess);
    if (j < 46) return 8'hA0;
    if (j == 46) return 8'h3C;
    return {~^bc, 1'b0, bc};
  endfunction : pkt_byte

  initial begin
    vid_valid = 1'b0;
    vid_byte  = 8'h00;
  end

  always @(posedge clk) begin
    if (go) begin
      for (i = 0; i < 56; i++) begin
        #1;
        vid_valid = 1'b1;
        vid_byte  = pkt_byte(i);
        @(posedge clk);
      end
      #1;
      vid_valid = 1'b0;
      // released bus must not look like the last byte
      vid_byte  = ~vid_byte;
    end
  end
endmodule : svc_decoder_model
`default_nettype wire

// ### verification/sliced_vbi_packet_corrector_test.sv
`timescale 1ns/10ps
`default_nettype none
module sliced_vbi_packet_corrector_test;
  logic       CLK, RESETN, ZERO_SKIP_MODE, go, VID_VALID;
  logic [7:0] VID_BYTE, spur_val, TEXT_DATA, PAYLOAD_BYTE_COUNT;
  logic [3:0] excess;
  logic       TEXT_VALID, TEXT_FIRST, TEXT_LAST, CORRECTED, BUSY;
  int         bad_count, total_checks, cycles;

  svc_decoder_model partner (.clk(CLK), .go(go), .excess(excess), .spur_val(spur_val),
    .vid_byte(VID_BYTE), .vid_valid(VID_VALID));

  svc_corrector uut (.CLK(CLK), .RESETN(RESETN), .VID_BYTE(VID_BYTE), .VID_VALID(VID_VALID),
    .ZERO_SKIP_MODE(ZERO_SKIP_MODE), .TEXT_DATA(TEXT_DATA), .TEXT_VALID(TEXT_VALID),
    .TEXT_FIRST(TEXT_FIRST), .TEXT_LAST(TEXT_LAST), .PAYLOAD_BYTE_COUNT(PAYLOAD_BYTE_COUNT),
    .CORRECTED(CORRECTED), .BUSY(BUSY));

  always #2.5 CLK = ~CLK;

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : check_byte

  task automatic check_bit(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  // one packet out of the partner, 35 bytes judged on the text side
  task automatic run_packet(input logic [3:0] e, input logic [7:0] spur);
    int n;
    excess   = e;
    spur_val = spur;
    go       = 1'b1;
    @(posedge CLK);
    #1 go = 1'b0;
    n = 0;
    while (TEXT_FIRST !== 1'b1 && n < 200) begin
      @(posedge CLK);
      #1 n++;
    end
    check_bit("text_first", 1'b1, TEXT_FIRST);
    check_bit("busy", 1'b1, BUSY);
    for (int k = 0; k < 35; k++) begin
      check_bit("text_valid", 1'b1, TEXT_VALID);
      check_byte("text_data", 8'h40 + 8'(k), TEXT_DATA);
      check_bit("text_last", k == 34, TEXT_LAST);
      @(posedge CLK);
      #1;
    end
    check_bit("text_valid_end", 1'b0, TEXT_VALID);
    check_byte("byte_count", 8'h25 + 8'(e), PAYLOAD_BYTE_COUNT);
    check_bit("corrected", e != 4'h0, CORRECTED);
    n = 0;
    while (BUSY !== 1'b0 && n < 100) begin
      @(posedge CLK);
      #1 n++;
    end
    check_bit("busy_end", 1'b0, BUSY);
  endtask : run_packet

  task automatic scen_reset_values();
    check_bit("text_valid_rst", 1'b0, TEXT_VALID);
    check_bit("corrected_rst", 1'b0, CORRECTED);
    check_byte("byte_count_rst", 8'h00, PAYLOAD_BYTE_COUNT);
    check_bit("busy_rst", 1'b0, BUSY);
  endtask : scen_reset_values

  task automatic scen_nominal();
    run_packet(4'h0, 8'hA5);
  endtask : scen_nominal

  // nonzero junk so a zero-skip slip in count mode shows up
  task automatic scen_spurious();
    run_packet(4'h2, 8'hA5);
    run_packet(4'h3, 8'hA5);
    run_packet(4'h0, 8'hA5);
  endtask : scen_spurious

  task automatic scen_zero_skip();
    ZERO_SKIP_MODE = 1'b1;
    repeat (3) @(posedge CLK);
    #1 run_packet(4'h3, 8'h00);
    ZERO_SKIP_MODE = 1'b0;
    repeat (3) @(posedge CLK);
    #1 run_packet(4'h2, 8'hA5);
  endtask : scen_zero_skip

  always @(posedge CLK) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      final_report();
    end
  end

  initial begin
    CLK            = 1'b0;
    RESETN         = 1'b0;
    ZERO_SKIP_MODE = 1'b0;
    go             = 1'b0;
    excess         = 4'h0;
    spur_val       = 8'h00;
    repeat (2) @(posedge CLK);
    #1 RESETN = 1'b1;
    scen_reset_values();
    scen_nominal();
    scen_spurious();
    scen_zero_skip();
    final_report();
  end
endmodule : sliced_vbi_packet_corrector_test
`default_nettype wire
